// ### hw/adc_host_ctrl.sv
// host controller for a dual sampling converter: start, select, clock, reset
// Behaviour
// - zero-latency reads lower chip select only after the data-ready time from start.
// - zero-latency starts are spaced by data-ready time plus the frame readout.
// - overlapped starts are at least 333 ns apart (16-bit) or 285 ns (14-bit).
// - overlapped reads lower chip select between 15 ns and 180 ns after start.
// - start stays low at least 15 ns between pulses.
// - start stays high at least 15 ns after each rising edge.
// - chip select rises no sooner than 14 ns after the last capture edge.
// - single-data-rate serial clock stays at or below 60 MHz.
// - double-data-rate serial clock stays at or below 22 MHz.
// - byte-wide parallel clock stays at or below 45 MHz.
// - a reset pulse on the reset/power-down pin lasts 50 ns to 500 ns low.
// - power-down holds the reset/power-down pin low at least 1000 ns.
`timescale 1ns/100ps
module adc_host_ctrl
    import adc_host_pkg::*;
#(
    parameter int unsigned RST_CYC = C_RST_MIN + 1, // reset pulse cycles
    parameter int unsigned PD_CYC  = C_PD_MIN       // power-down cycles
) (
    input  wire logic                   ref_clk,   // 100 MHz clock
    input  wire logic                   rst,       // async reset, high
    input  wire adc_host_pkg::conv_req_t req,      // conversion request
    input  wire logic                   req_valid, // request strobe
    output logic                        req_ready_ff, // can take request
    input  wire logic                   do_reset,  // pulse: reset converter
    input  wire logic                   pd_req,    // level: power down
    input  wire logic                   ready_pin, // converter ready pin
    output adc_host_pkg::adc_pins_t     pins_ff,   // pins to converter
    output logic                        frame_done_ff, // pulse: frame ended
    output logic                        ready_late_ff  // sticky: ready missed
);
    // counts that do not fit the phase counters are refused
    if (C_CS_MIN > C_CS_MAX || C_DRDY16 > 255 || C_CYC16 > 255) begin : g_bad_timing
        $error("adc_host_ctrl: timing constants cannot be served");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HIGH,
        ST_WAITCS,
        ST_FRAME,
        ST_HOLD,
        ST_GAP
    } st_t;

    st_t              st_ff, nxt_st;
    conv_req_t        cur_ff, nxt_cur;
    logic [CNT_W-1:0] t_ff, nxt_t;      // cycles since start rising edge
    logic [CNT_W-1:0] h_ff, nxt_h;      // cycles in current phase
    logic             conv_ff, nxt_conv;
    logic             cs_n_ff, nxt_cs_n;
    logic             nxt_rdy, nxt_fdone;
    logic             run;
    logic             sclk, last_cap, clk_done;
    logic             rp_n, rp_busy;
    logic             rdy_s1_ff, rdy_s2_ff;
    logic             late_ff, nxt_late;

    // wait after start before selecting; zone 2 uses the earliest legal point
    function automatic logic [CNT_W-1:0] cs_delay(input conv_req_t r);
        if (r.zone2) begin
            cs_delay = CNT_W'(C_CS_MIN);
        end else if (r.res14) begin
            cs_delay = CNT_W'(C_DRDY14);
        end else begin
            cs_delay = CNT_W'(C_DRDY16);
        end
    endfunction

    // least start-to-start spacing for overlapped reads
    function automatic logic [CNT_W-1:0] cyc_min(input conv_req_t r);
        cyc_min = r.res14 ? CNT_W'(C_CYC14) : CNT_W'(C_CYC16);
    endfunction

    adc_sclk_gen u_sclk (
        .clk     (ref_clk),
        .rst     (rst),
        .run     (run),
        .proto   (cur_ff.proto),
        .nclk    (cur_ff.nclk),
        .sclk_ff (sclk),
        .last_ff (last_cap),
        .done_ff (clk_done)
    );

    adc_rst_pulse #(
        .RST_CYC (RST_CYC),
        .PD_CYC  (PD_CYC)
    ) u_rstpd (
        .clk         (ref_clk),
        .rst         (rst),
        .do_reset    (do_reset),
        .pd_req      (pd_req),
        .rst_pd_n_ff (rp_n),
        .busy_ff     (rp_busy)
    );

    assign run = (st_ff == ST_FRAME);

    // ready pin passes two flops before use
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdy_s1_ff <= 1'b0;
            rdy_s2_ff <= 1'b0;
        end else begin
            rdy_s1_ff <= ready_pin;
            rdy_s2_ff <= rdy_s1_ff;
        end
    end

    // conversion sequencer; starts are blocked while a reset pulse runs
    always_comb begin
        nxt_st    = st_ff;
        nxt_cur   = cur_ff;
        nxt_t     = (t_ff == '1) ? t_ff : t_ff + CNT_W'(1);
        nxt_h     = (h_ff == '1) ? h_ff : h_ff + CNT_W'(1);
        nxt_conv  = conv_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_fdone = 1'b0;
        nxt_late  = late_ff;
        case (st_ff)
            ST_IDLE: begin
                if (req_valid && !rp_busy && rp_n) begin
                    nxt_cur  = req;
                    nxt_conv = 1'b1;
                    nxt_t    = CNT_W'(1);
                    nxt_h    = CNT_W'(1);
                    nxt_st   = ST_HIGH;
                end
            end
            ST_HIGH: begin
                // high time and select delay both counted from the rising edge
                if (t_ff >= CNT_W'(C_WH)) begin
                    nxt_conv = 1'b0;
                end
                if (t_ff >= CNT_W'(C_WH) && t_ff + CNT_W'(1) >= cs_delay(cur_ff)) begin
                    nxt_st   = ST_WAITCS;
                end
            end
            ST_WAITCS: begin
                nxt_conv = 1'b0;
                if (t_ff >= cs_delay(cur_ff)) begin
                    nxt_cs_n = 1'b0;
                    nxt_h    = '0;
                    nxt_st   = ST_FRAME;
                    // ready should already be up in 16-bit zero-latency mode
                    if (!cur_ff.zone2 && !cur_ff.res14 && !rdy_s2_ff) begin
                        nxt_late = 1'b1;
                    end
                end
            end
            ST_FRAME: begin
                if (last_cap) begin
                    nxt_h = '0;
                end
                if (clk_done) begin
                    nxt_st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // margin after last capture edge before deselect
                if (h_ff >= CNT_W'(C_CKCS)) begin
                    nxt_cs_n  = 1'b1;
                    nxt_fdone = 1'b1;
                    nxt_h     = CNT_W'(1);
                    nxt_st    = ST_GAP;
                end
            end
            ST_GAP: begin
                // zero-latency spacing follows from the serial readout; overlapped
                // spacing is padded to the cycle minimum
                if (h_ff >= CNT_W'(C_WL) && (!cur_ff.zone2 || t_ff >= cyc_min(cur_ff))) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    assign nxt_rdy = (nxt_st == ST_IDLE) && !rp_busy;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff         <= ST_IDLE;
            cur_ff        <= '0;
            t_ff          <= '0;
            h_ff          <= '0;
            conv_ff       <= 1'b0;
            cs_n_ff       <= 1'b1;
            late_ff       <= 1'b0;
            req_ready_ff  <= 1'b0;
            frame_done_ff <= 1'b0;
        end else begin
            st_ff         <= nxt_st;
            cur_ff        <= nxt_cur;
            t_ff          <= nxt_t;
            h_ff          <= nxt_h;
            conv_ff       <= nxt_conv;
            cs_n_ff       <= nxt_cs_n;
            late_ff       <= nxt_late;
            req_ready_ff  <= nxt_rdy;
            frame_done_ff <= nxt_fdone;
        end
    end

    // pin register; sclk and reset pin come from flops in the submodules
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pins_ff       <= '{conversion_start: 1'b0, cs_n: 1'b1, sclk: 1'b0, rst_pd_n: 1'b1};
            ready_late_ff <= 1'b0;
        end else begin
            pins_ff.conversion_start <= conv_ff;
            pins_ff.cs_n             <= cs_n_ff;
            pins_ff.sclk             <= sclk;
            pins_ff.rst_pd_n         <= rp_n;
            ready_late_ff            <= late_ff;
        end
    end

    // helper counters for pin-level checks
    logic [CNT_W-1:0] hi_ff, lo_ff, since_ff, fall_ff;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hi_ff    <= '0;
            lo_ff    <= '0;
            since_ff <= '1;
            fall_ff  <= '0;
        end else begin
            hi_ff    <= pins_ff.conversion_start ? hi_ff + CNT_W'(1) : '0;
            lo_ff    <= pins_ff.conversion_start ? '0 : ((lo_ff == '1) ? lo_ff : lo_ff + CNT_W'(1));
            since_ff <= (conv_ff && !pins_ff.conversion_start) ? CNT_W'(1)
                        : ((since_ff == '1) ? since_ff : since_ff + CNT_W'(1));
            // cycles the serial clock has been low, saturating
            fall_ff  <= sclk ? '0 : ((fall_ff == '1) ? fall_ff : fall_ff + CNT_W'(1));
        end
    end

    conv_high_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pins_ff.conversion_start) |-> $past(hi_ff) + CNT_W'(1) >= CNT_W'(C_WH))
        else $error("start high pulse too short");
    conv_low_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pins_ff.conversion_start) |-> $past(lo_ff) >= CNT_W'(C_WL))
        else $error("start low time too short");
    zone2_cs_win_a: assert property (@(posedge ref_clk) disable iff (rst)
        ($fell(pins_ff.cs_n) && cur_ff.zone2) |->
            ($past(since_ff) >= CNT_W'(C_CS_MIN) && $past(since_ff) <= CNT_W'(C_CS_MAX)))
        else $error("overlapped select outside window");
    zero_lat_cs_a: assert property (@(posedge ref_clk) disable iff (rst)
        ($fell(pins_ff.cs_n) && !cur_ff.zone2) |->
            $past(since_ff) >= (cur_ff.res14 ? CNT_W'(C_DRDY14) : CNT_W'(C_DRDY16)))
        else $error("zero-latency select before data ready");
    zone2_cycle_a: assert property (@(posedge ref_clk) disable iff (rst)
        ($rose(pins_ff.conversion_start) && $past(cur_ff.zone2, 2)) |->
            $past(since_ff) >= ($past(cur_ff.res14, 2) ? CNT_W'(C_CYC14) : CNT_W'(C_CYC16)))
        else $error("overlapped start spacing too short");
    cs_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        last_cap |-> ##1 (!cs_n_ff [*2]))
        else $error("select rose too soon after last capture");
    sclk_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
        ($rose(sclk) && run) |-> fall_ff >=
            (cur_ff.proto == PROTO_DDR ? CNT_W'(HALF_DDR) :
             cur_ff.proto == PROTO_PAR ? CNT_W'(HALF_PAR) : CNT_W'(HALF_SDR)))
        else $error("serial clock low phase too short");
    idle_pins_a: assert property (@(posedge ref_clk) disable iff (rst)
        frame_done_ff |=> (pins_ff.cs_n && !pins_ff.conversion_start) [*2])
        else $error("start raised while frame closing");

    zone1_frame_c: cover property (@(posedge ref_clk) disable iff (rst)
        frame_done_ff && !cur_ff.zone2);
    zone2_frame_c: cover property (@(posedge ref_clk) disable iff (rst)
        frame_done_ff && cur_ff.zone2);
    ddr_frame_c: cover property (@(posedge ref_clk) disable iff (rst)
        frame_done_ff && cur_ff.proto == PROTO_DDR);
endmodule

// ### hw/adc_host_pkg.sv
// shared constants and types for the converter host controller
package adc_host_pkg;
    localparam int unsigned CLK_MHZ         = 100;
    // nanosecond and megahertz figures of the converter timing
    localparam int unsigned T_DRDY16_NS     = 315;
    localparam int unsigned T_DRDY14_NS     = 280;
    localparam int unsigned T_CYC16_NS      = 333;
    localparam int unsigned T_CYC14_NS      = 285;
    localparam int unsigned T_CS_MIN_NS     = 15;
    localparam int unsigned T_CS_MAX_NS     = 180;
    localparam int unsigned T_WL_CONV_NS    = 15;
    localparam int unsigned T_WH_CONV_NS    = 15;
    localparam int unsigned T_CKCS_NS       = 14;
    localparam int unsigned F_SDR_MHZ       = 60;
    localparam int unsigned F_DDR_MHZ       = 22;
    localparam int unsigned F_PAR_MHZ       = 45;
    localparam int unsigned T_RST_MIN_NS    = 50;
    localparam int unsigned T_RST_MAX_NS    = 500;
    localparam int unsigned T_PD_MIN_NS     = 1000;
    // cycle counts: least times round up, longest times round down
    localparam int unsigned C_DRDY16 = (T_DRDY16_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_DRDY14 = (T_DRDY14_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_CYC16  = (T_CYC16_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_CYC14  = (T_CYC14_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_CS_MIN = (T_CS_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_CS_MAX = (T_CS_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned C_WL     = (T_WL_CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_WH     = (T_WH_CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_CKCS   = (T_CKCS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_RST_MIN = (T_RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned C_RST_MAX = (T_RST_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned C_PD_MIN = (T_PD_MIN_NS * CLK_MHZ + 999) / 1000;
    // serial clock half periods in ref cycles; period >= 1/fmax
    localparam int unsigned HALF_SDR = (CLK_MHZ + 2 * F_SDR_MHZ - 1) / (2 * F_SDR_MHZ);
    localparam int unsigned HALF_DDR = (CLK_MHZ + 2 * F_DDR_MHZ - 1) / (2 * F_DDR_MHZ);
    localparam int unsigned HALF_PAR = (CLK_MHZ + 2 * F_PAR_MHZ - 1) / (2 * F_PAR_MHZ);
    localparam int unsigned CNT_W    = 8;

    typedef enum logic [1:0] {
        PROTO_SDR,
        PROTO_DDR,
        PROTO_PAR
    } proto_t;

    // one conversion request
    typedef struct packed {
        logic       zone2;      // overlapped read window
        logic       res14;      // 14-bit variant timing
        proto_t     proto;      // read protocol
        logic [7:0] nclk;       // serial clocks in the frame
    } conv_req_t;

    // pins driven toward the converter
    typedef struct packed {
        logic conversion_start;
        logic cs_n;
        logic sclk;
        logic rst_pd_n;
    } adc_pins_t;
endpackage

// ### hw/adc_sclk_gen.sv
// serial clock generator with per-protocol rate limit
`timescale 1ns/100ps
module adc_sclk_gen
    import adc_host_pkg::*;
(
    input  wire logic                clk,      // reference clock
    input  wire logic                rst,      // async reset, high
    input  wire logic                run,      // frame active
    input  wire adc_host_pkg::proto_t proto,   // selects rate
    input  wire logic [7:0]          nclk,     // clocks in frame
    output logic                     sclk_ff,  // serial clock
    output logic                     last_ff,  // pulse at last capture edge
    output logic                     done_ff   // frame clocks finished
);
    logic [CNT_W-1:0] div_ff, nxt_div;
    logic [7:0]       cnt_ff, nxt_cnt;
    logic             nxt_sclk, nxt_last, nxt_done;
    logic [CNT_W-1:0] half;

    // half period never shorter than the protocol limit
    always_comb begin
        case (proto)
            PROTO_SDR: half = CNT_W'(HALF_SDR);
            PROTO_DDR: half = CNT_W'(HALF_DDR);
            PROTO_PAR: half = CNT_W'(HALF_PAR);
            default:   half = CNT_W'(HALF_DDR);
        endcase
    end

    // divider toggles sclk; capture edge is the rising edge
    always_comb begin
        nxt_div  = div_ff;
        nxt_cnt  = cnt_ff;
        nxt_sclk = sclk_ff;
        nxt_last = 1'b0;
        nxt_done = done_ff;
        if (!run) begin
            nxt_div  = '0;
            nxt_cnt  = '0;
            nxt_sclk = 1'b0;
            nxt_done = 1'b0;
        end else if (!done_ff) begin
            if (div_ff + CNT_W'(1) >= half) begin
                nxt_div  = '0;
                nxt_sclk = ~sclk_ff;
                if (!sclk_ff) begin
                    nxt_cnt = cnt_ff + 8'h01;
                    if (cnt_ff + 8'h01 >= nclk) begin
                        nxt_last = 1'b1;
                    end
                end else if (cnt_ff >= nclk) begin
                    nxt_done = 1'b1; // clock parked low after last high phase
                end
            end else begin
                nxt_div = div_ff + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff  <= '0;
            cnt_ff  <= '0;
            sclk_ff <= 1'b0;
            last_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            cnt_ff  <= nxt_cnt;
            sclk_ff <= nxt_sclk;
            last_ff <= nxt_last;
            done_ff <= nxt_done;
        end
    end
endmodule

// ### hw/adc_rst_pulse.sv
// reset / power-down low pulse generator
`timescale 1ns/100ps
module adc_rst_pulse
    import adc_host_pkg::*;
#(
    parameter int unsigned RST_CYC = C_RST_MIN + 1, // reset pulse length
    parameter int unsigned PD_CYC  = C_PD_MIN       // power-down least length
) (
    input  wire logic clk,         // reference clock
    input  wire logic rst,         // async reset, high
    input  wire logic do_reset,    // pulse: request reset
    input  wire logic pd_req,      // level: hold power-down
    output logic      rst_pd_n_ff, // pin level, low active
    output logic      busy_ff      // pulse in progress
);
    // refused lengths: outside the pin windows or beyond the 11-bit counter
    if (RST_CYC < C_RST_MIN || RST_CYC > C_RST_MAX ||
        PD_CYC < C_PD_MIN || PD_CYC > 2047) begin : g_bad_len
        $error("adc_rst_pulse: pulse lengths out of range");
    end

    typedef enum logic [1:0] {RP_IDLE, RP_RST, RP_PD} rp_state_t;
    rp_state_t        st_ff, nxt_st;
    logic [10:0]      cnt_ff, nxt_cnt;
    logic             nxt_pin, nxt_busy;

    // a reset pulse always ends within its max; power-down never ends early
    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_pin  = 1'b1;
        nxt_busy = 1'b0;
        case (st_ff)
            RP_IDLE: begin
                nxt_cnt = '0;
                if (pd_req) begin
                    nxt_st = RP_PD;
                end else if (do_reset) begin
                    nxt_st = RP_RST;
                end
            end
            RP_RST: begin
                nxt_cnt = cnt_ff + 11'h001;
                if (cnt_ff + 11'h001 >= 11'(RST_CYC)) begin
                    nxt_st = RP_IDLE;
                end
            end
            RP_PD: begin
                if (cnt_ff < 11'(PD_CYC)) begin
                    nxt_cnt = cnt_ff + 11'h001;
                end else if (!pd_req) begin
                    nxt_st = RP_IDLE;
                end
            end
            default: nxt_st = RP_IDLE;
        endcase
        if (nxt_st != RP_IDLE) begin
            nxt_pin  = 1'b0;
            nxt_busy = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff       <= RP_IDLE;
            cnt_ff      <= '0;
            rst_pd_n_ff <= 1'b1;
            busy_ff     <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            cnt_ff      <= nxt_cnt;
            rst_pd_n_ff <= nxt_pin;
            busy_ff     <= nxt_busy;
        end
    end

    // low time counter for checks
    logic [10:0] low_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_ff <= '0;
        end else begin
            // saturates so a long power-down hold cannot wrap to a short count
            low_ff <= rst_pd_n_ff ? 11'h000 : ((low_ff == '1) ? low_ff : low_ff + 11'h001);
        end
    end

    rst_pd_window_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(rst_pd_n_ff) && $past(st_ff) == RP_RST) |->
            ($past(low_ff) + 11'h001 >= 11'(C_RST_MIN) &&
             $past(low_ff) + 11'h001 <= 11'(C_RST_MAX)))
        else $error("reset pulse length outside window");
    pd_min_len_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(rst_pd_n_ff) && $past(st_ff) == RP_PD) |->
            $past(low_ff) + 11'h001 >= 11'(C_PD_MIN))
        else $error("power-down pulse too short");
    rst_pulse_c: cover property (@(posedge clk) disable iff (rst)
        $rose(rst_pd_n_ff) && $past(st_ff) == RP_RST);
endmodule

// ### tb/adc_dev_model.sv
// behavioural converter: ready output after each conversion start
`timescale 1ns/100ps
module adc_dev_model (
    input  wire logic conversion_start, // start pin from host
    input  wire logic cs_n,             // chip select, low active
    input  wire logic rst_pd_n,         // reset / power-down pin
    input  wire logic slow,             // late but legal ready
    output logic      ready_pin         // ready toward host
);
    initial ready_pin = 1'b0;
    // ready rises inside the data-ready limit; slow case still legal
    always @(posedge conversion_start) begin
        #(slow ? 250 : 60);
        if (rst_pd_n) ready_pin = 1'b1;
    end
    // selection or a held reset pin clears the indication
    always @(negedge cs_n or negedge rst_pd_n) ready_pin = 1'b0;
endmodule

// ### tb/adc_host_ctrl_tb.sv
// self-checking bench for the converter host controller
`timescale 1ns/100ps
module adc_host_ctrl_tb;
    import adc_host_pkg::*;
    logic        ref_clk, rst, req_valid, do_reset, pd_req, ready_pin, slow, pz2, pr14;
    logic        req_ready_ff, frame_done_ff, ready_late_ff;
    conv_req_t   req;
    adc_pins_t   pins_ff, pv;
    int          mismatches, n_tests, sp, lw, th, wh, cd, nr, mh, hp, tr, pl;
    int          lo_q[$], hi_q[$];
    logic [15:0] lfsr;
    localparam int BIG = 1 << 30;

    adc_host_ctrl i_adc_host_ctrl (.ref_clk(ref_clk), .rst(rst), .req(req),
        .req_valid(req_valid), .req_ready_ff(req_ready_ff), .do_reset(do_reset),
        .pd_req(pd_req), .ready_pin(ready_pin), .pins_ff(pins_ff),
        .frame_done_ff(frame_done_ff), .ready_late_ff(ready_late_ff));
    adc_dev_model i_adc_dev_model (.conversion_start(pins_ff.conversion_start),
        .cs_n(pins_ff.cs_n), .rst_pd_n(pins_ff.rst_pd_n), .slow(slow), .ready_pin(ready_pin));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic note(input int lo, input int hi);
        lo_q.push_back(lo);
        hi_q.push_back(hi);
    endtask

    // oldest note against a measured figure
    task automatic chk(input string nm, input int v);
        int lo, hi;
        n_tests++;
        lo = (lo_q.size() > 0) ? lo_q.pop_front() : BIG;
        hi = (hi_q.size() > 0) ? hi_q.pop_front() : -1;
        if (v < lo || v > hi) begin
            mismatches++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask

    // one request, notes first, then waits until the sequence is over
    task automatic conv(input logic z2, input logic r14, input proto_t p,
                        input logic [7:0] n, input bit first);
        int dr, hf, gp;
        dr = r14 ? C_DRDY14 : C_DRDY16;
        hf = (p == PROTO_SDR) ? HALF_SDR : (p == PROTO_DDR) ? HALF_DDR : HALF_PAR;
        // start spacing is owed to the previous frame
        gp = pz2 ? (pr14 ? C_CYC14 : C_CYC16) : (pr14 ? C_DRDY14 : C_DRDY16) + 1;
        note(first ? 0 : gp, BIG);
        note(first ? 0 : C_WL, BIG);
        note(z2 ? C_CS_MIN : dr, z2 ? C_CS_MAX : dr + 2);
        note(C_WH, BIG);
        note(n, n);
        note(hf, hf);
        note(C_CKCS, BIG);
        pz2 = z2;
        pr14 = r14;
        @(posedge ref_clk);
        req <= '{zone2: z2, res14: r14, proto: p, nclk: n};
        req_valid <= 1'b1;
        do @(posedge ref_clk); while (req_ready_ff !== 1'b1);
        req_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        while (req_ready_ff !== 1'b1) @(posedge ref_clk);
    endtask

    // pin watcher: times every frame and pin pulse
    always @(posedge ref_clk) begin
        if (rst) begin
            pv = pins_ff;
            {sp, lw, th, tr, pl, hp, nr, mh, wh, cd} = '0;
        end else begin
            sp++; lw++; th++; tr++; pl++; hp++;
            if (pins_ff.conversion_start && !pv.conversion_start) begin
                chk("start_gap", sp);
                chk("start_low", lw);
                sp = 0;
                th = 0;
            end
            if (!pins_ff.conversion_start && pv.conversion_start) begin
                wh = th;
                lw = 0;
            end
            if (!pins_ff.cs_n && pv.cs_n) begin
                cd = sp;
                nr = 0;
                mh = BIG;
            end
            // first half period skipped: it is the select set-up, not the rate
            if (pins_ff.sclk !== pv.sclk) begin
                if (nr > 0 && hp < mh) mh = hp;
                hp = 0;
                if (pins_ff.sclk) begin
                    nr++;
                    tr = 0;
                end
            end
            if (pins_ff.cs_n && !pv.cs_n) begin
                chk("cs_delay", cd);
                chk("start_high", wh);
                chk("sclk_rises", nr);
                chk("sclk_half", mh);
                chk("cs_tail", tr);
            end
            if (pins_ff.rst_pd_n && !pv.rst_pd_n) chk("pin_low", pl);
            if (!pins_ff.rst_pd_n && pv.rst_pd_n) pl = 0;
            pv = pins_ff;
        end
    end

    // hang guard, well beyond the longest run
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        do_reset = 1'b0;
        pd_req = 1'b0;
        slow = 1'b0;
        req = '0;
        lfsr = 16'h3542;
        mismatches = 0;
        n_tests = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        conv(1'b1, 1'b0, PROTO_SDR, 8'h02, 1'b1);
        conv(1'b1, 1'b0, PROTO_SDR, 8'h01, 1'b0);
        conv(1'b0, 1'b0, PROTO_SDR, 8'h10, 1'b0);
        slow <= 1'b1;
        conv(1'b0, 1'b1, PROTO_DDR, 8'h08, 1'b0);
        conv(1'b1, 1'b1, PROTO_PAR, 8'h04, 1'b0);
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            slow <= lfsr[0];
            conv(lfsr[1], lfsr[2], lfsr[4] ? PROTO_PAR : (lfsr[3] ? PROTO_DDR : PROTO_SDR),
                 {4'h0, lfsr[8:5]} + 8'h01, 1'b0);
        end
        note(C_RST_MIN, C_RST_MAX);
        @(posedge ref_clk);
        do_reset <= 1'b1;
        @(posedge ref_clk);
        do_reset <= 1'b0;
        repeat (20) @(posedge ref_clk);
        // a request during power-down must leave the pins alone
        note(C_PD_MIN, BIG);
        pd_req <= 1'b1;
        repeat (10) @(posedge ref_clk);
        req_valid <= 1'b1;
        repeat (20) @(posedge ref_clk);
        req_valid <= 1'b0;
        repeat (10) @(posedge ref_clk);
        pd_req <= 1'b0;
        repeat (150) @(posedge ref_clk);
        conv(1'b0, 1'b0, PROTO_DDR, 8'h03, 1'b0);
        n_tests++;
        if (ready_late_ff !== 1'b0 || lo_q.size() != 0) begin
            mismatches++;
            $display("[ERR] ready_late expected 0 seen %b, notes left %0d", ready_late_ff,
                     lo_q.size());
        end
        stop_test();
    end
endmodule
